// ===== verilog/eewr_slave.sv
// two-wire eeprom slave: pin filtering, framing, select, protect, write timing
`timescale 1ns/10ps
module eewr_slave
  import eewr_pkg::*;
#(
  parameter logic [3:0] DEV_TYPE = DEV_TYPE_DEF,
  parameter bit         HAS_WP   = 1'b1,
  parameter int         WC_CYC   = WC_CYC_DEF
) (
  input  wire logic     mclk,
  input  wire logic     rst,
  input  wire logic     sclIn,
  input  wire logic     sdaIn,
  output logic          sdaOut,
  output logic          sdaOeN,
  input  wire logic     chipSelectStrap0,
  input  wire logic     chipSelectStrap1,
  input  wire logic     chipSelectStrap2,
  input  wire logic     writeProtect,
  input  wire logic     lowSupply,
  output logic [7:0]    rdAddr,
  input  wire logic [7:0] rdData,
  output logic          wrValid,
  output eewr_wr_s      wrWord,
  input  wire logic     wrReady,
  output logic          wrCommit,
  output logic          wcBusy
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  logic [PIN_N-1:0]    pinS1;
  logic [PIN_N-1:0]    pinS2;
  logic [FILT_CYC-1:0] lineHist [2];
  logic [FILT_CYC-1:0] next_lineHist [2];
  logic                lineF [2];
  logic                next_lineF [2];
  logic                sclD;
  logic                sdaD;
  logic                sclF;
  logic                sdaF;
  logic                sclRise;
  logic                sclFall;
  logic                startCond;
  logic                stopCond;
  logic                wpEff;

  // two-flop synchroniser on every pin, first stage feeds only the second
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pinS1 <= '1;
      pinS2 <= '1;
    end else begin
      pinS1 <= {lowSupply, writeProtect, chipSelectStrap2, chipSelectStrap1,
                chipSelectStrap0, sdaIn, sclIn};
      pinS2 <= pinS1;
    end
  end

  // spike filter: a level is taken only after it stands for all history samples
  for (genvar i = 0; i < 2; i++) begin : g_filt
    always_comb begin
      next_lineHist[i] = {lineHist[i][FILT_CYC-2:0], pinS2[i]};
      next_lineF[i]    = lineF[i];
      if (&next_lineHist[i]) begin
        next_lineF[i] = 1'b1;
      end else if (~|next_lineHist[i]) begin
        next_lineF[i] = 1'b0;
      end
    end
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        lineHist[i] <= '1;
        lineF[i]    <= 1'b1;
      end else begin
        lineHist[i] <= next_lineHist[i];
        lineF[i]    <= next_lineF[i];
      end
    end
    AST_FILTER_STABLE : assert property ($changed(lineF[i]) |->
        lineHist[i] == {FILT_CYC{lineF[i]}})
      else $error("filtered line moved without a stable history");
  end

  assign sclF = lineF[PIN_SCL];
  assign sdaF = lineF[PIN_SDA];

  // one-cycle delayed copies for edge and condition detection
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sclD <= 1'b1;
      sdaD <= 1'b1;
    end else begin
      sclD <= sclF;
      sdaD <= sdaF;
    end
  end

  assign sclRise   = sclF && !sclD;
  assign sclFall   = !sclF && sclD;
  assign startCond = sclF && sclD && sdaD && !sdaF;
  assign stopCond  = sclF && sclD && !sdaD && sdaF;
  assign wpEff     = HAS_WP ? pinS2[PIN_WP] : 1'b0;

  eewr_state_e state, next_state;
  logic [3:0]  bitCnt, next_bitCnt;
  logic [1:0]  byteIdx, next_byteIdx;
  logic [7:0]  shiftReg, next_shiftReg;
  logic [7:0]  ptr, next_ptr;
  logic        rw, next_rw;
  logic        ackOk, next_ackOk;
  logic        wrPending, next_wrPending;
  logic [2:0]  csLat, next_csLat;
  logic        wpLat, next_wpLat;
  logic        pendLow, next_pendLow;
  logic [3:0]  holdCnt, next_holdCnt;
  logic        sdaLow, next_sdaLow;
  logic        next_wcBusy;
  logic [23:0] wcTimer, next_wcTimer;
  logic        next_wrCommit;
  logic [7:0]  shiftNext;
  logic        push;
  logic        bufReady;
  logic        blocked;
  eewr_wr_s    pushWord;

  assign shiftNext = {shiftReg[6:0], sdaF};
  assign blocked   = wpLat || pinS2[PIN_LOW];
  assign pushWord  = '{addr: ptr, data: shiftNext};

  // framing, select and write control
  always_comb begin
    next_state    = state;
    next_bitCnt   = bitCnt;
    next_byteIdx  = byteIdx;
    next_shiftReg = shiftReg;
    next_ptr      = ptr;
    next_rw       = rw;
    next_ackOk    = ackOk;
    next_wrPending = wrPending;
    next_csLat    = csLat;
    next_wpLat    = wpLat;
    next_pendLow  = pendLow;
    next_holdCnt  = holdCnt;
    next_sdaLow   = sdaLow;
    next_wcBusy   = wcBusy;
    next_wcTimer  = wcTimer;
    next_wrCommit = 1'b0;
    push          = 1'b0;
    // driven level only moves once the hold count after a fall runs out
    if (holdCnt != 4'h0) begin
      next_holdCnt = 4'(holdCnt - 4'h1);
      if (holdCnt == 4'h1) begin
        next_sdaLow = pendLow;
      end
    end
    if (wcBusy) begin
      next_wcTimer = 24'(wcTimer - 24'h1);
      if (wcTimer == 24'h1) begin
        next_wcBusy = 1'b0;
      end
    end
    if (startCond) begin
      next_state   = ST_RX;
      next_bitCnt  = 4'h0;
      next_byteIdx = 2'h0;
      next_csLat   = pinS2[PIN_CS0 +: 3];
      next_wpLat   = wpEff;
      next_pendLow = 1'b0;
      next_holdCnt = HOLD_CYC;
    end else if (stopCond) begin
      next_state   = ST_IDLE;
      next_pendLow = 1'b0;
      next_holdCnt = HOLD_CYC;
      if (wrPending) begin
        // protected or starved writes still run the whole cycle time
        next_wrPending = 1'b0;
        next_wcBusy    = 1'b1;
        next_wcTimer   = 24'(WC_CYC);
        next_wrCommit  = !blocked;
      end
    end else begin
      case (state)
        ST_RX: begin
          if (sclRise && bitCnt < 4'h8) begin
            next_shiftReg = shiftNext;
            next_bitCnt   = 4'(bitCnt + 4'h1);
            if (bitCnt == 4'h7) begin
              if (byteIdx == 2'h0) begin
                next_ackOk = (shiftNext[7:CTRL_TYPE_LSB] == DEV_TYPE) &&
                             (shiftNext[CTRL_CS_LSB +: 3] == csLat) &&
                             !wcBusy;
                next_rw    = shiftNext[CTRL_RW_BIT];
              end else if (byteIdx == 2'h1) begin
                next_ptr   = shiftNext;
                next_ackOk = 1'b1;
              end else begin
                // full buffer is refused by withholding the acknowledge
                next_ackOk = blocked || bufReady;
                if (blocked || bufReady) begin
                  push           = !blocked;
                  next_wrPending = 1'b1;
                  next_ptr       = {ptr[7:PAGE_BITS], PAGE_BITS'(ptr[PAGE_BITS-1:0] + 1'b1)};
                end
              end
            end
          end else if (sclFall && bitCnt == 4'h8) begin
            next_bitCnt  = 4'h0;
            next_holdCnt = HOLD_CYC;
            next_pendLow = ackOk;
            next_state   = ackOk ? ST_ACK : ST_IDLE;
          end
        end
        ST_ACK: begin
          if (sclFall) begin
            next_holdCnt = HOLD_CYC;
            next_bitCnt  = 4'h0;
            if (byteIdx == 2'h0 && rw) begin
              next_state    = ST_TX;
              next_shiftReg = rdData;
              next_pendLow  = !rdData[7];
            end else begin
              next_state   = ST_RX;
              next_pendLow = 1'b0;
              next_byteIdx = (byteIdx == 2'h0) ? 2'h1 : 2'h2;
            end
          end
        end
        ST_TX: begin
          if (sclFall) begin
            next_holdCnt = HOLD_CYC;
            if (bitCnt == 4'h7) begin
              next_pendLow = 1'b0;
              next_state   = ST_MACK;
              next_bitCnt  = 4'h0;
              next_ptr     = 8'(ptr + 8'h1);
            end else begin
              next_shiftReg = {shiftReg[6:0], 1'b0};
              next_pendLow  = !shiftReg[6];
              next_bitCnt   = 4'(bitCnt + 4'h1);
            end
          end
        end
        ST_MACK: begin
          if (sclRise) begin
            next_ackOk = !sdaF;
          end else if (sclFall) begin
            next_holdCnt  = HOLD_CYC;
            next_bitCnt   = 4'h0;
            next_shiftReg = rdData;
            next_pendLow  = ackOk && !rdData[7];
            next_state    = ackOk ? ST_TX : ST_IDLE;
          end
        end
        ST_IDLE: begin
          next_bitCnt = 4'h0;
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  // control registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state     <= ST_IDLE;
      bitCnt    <= 4'h0;
      byteIdx   <= 2'h0;
      shiftReg  <= 8'h00;
      ptr       <= PTR_RST;
      rw        <= 1'b0;
      ackOk     <= 1'b0;
      wrPending <= 1'b0;
      csLat     <= 3'h0;
      wpLat     <= 1'b0;
      pendLow   <= 1'b0;
      holdCnt   <= 4'h0;
      sdaLow    <= 1'b0;
      wcBusy    <= 1'b0;
      wcTimer   <= 24'h000000;
      wrCommit  <= 1'b0;
      sdaOut    <= 1'b0;
      sdaOeN    <= 1'b1;
    end else begin
      state     <= next_state;
      bitCnt    <= next_bitCnt;
      byteIdx   <= next_byteIdx;
      shiftReg  <= next_shiftReg;
      ptr       <= next_ptr;
      rw        <= next_rw;
      ackOk     <= next_ackOk;
      wrPending <= next_wrPending;
      csLat     <= next_csLat;
      wpLat     <= next_wpLat;
      pendLow   <= next_pendLow;
      holdCnt   <= next_holdCnt;
      sdaLow    <= next_sdaLow;
      wcBusy    <= next_wcBusy;
      wcTimer   <= next_wcTimer;
      wrCommit  <= next_wrCommit;
      sdaOut    <= 1'b0;
      sdaOeN    <= !next_sdaLow; // open drain: enable low only while pulling low
    end
  end

  assign rdAddr = ptr;

  eewr_buf #(.DEPTH(2)) u_buf (
    .mclk     (mclk),
    .rst      (rst),
    .inValid  (push),
    .inWord   (pushWord),
    .inReady  (bufReady),
    .outValid (wrValid),
    .outWord  (wrWord),
    .outReady (wrReady)
  );

  AST_HOLD_AFTER_FALL : assert property (sclFall |=> $stable(sdaLow)[*2])
    else $error("driven data moved too soon after clock fall");
  AST_START_RX : assert property (startCond |=> (state == ST_RX && bitCnt == 4'h0))
    else $error("start condition not taken");
  AST_STOP_IDLE : assert property (stopCond |=> state == ST_IDLE)
    else $error("stop condition not taken");
  AST_NO_ACK_BUSY : assert property ((state == ST_ACK && byteIdx == 2'h0) |-> !wcBusy)
    else $error("acknowledge during write cycle");
  AST_SELECT_MISMATCH : assert property ((state == ST_RX && byteIdx == 2'h0 && sclRise &&
      bitCnt == 4'h7 && shiftNext[CTRL_CS_LSB +: 3] != csLat) |=> !ackOk)
    else $error("acknowledged a foreign select code");
  AST_WP_NO_PUSH : assert property (push |-> !wpLat)
    else $error("write forwarded while protected");
  AST_LOW_SUPPLY_BLOCK : assert property ((push || next_wrCommit) |-> !pinS2[PIN_LOW])
    else $error("write forwarded under low supply");
  AST_PAGE_WRAP : assert property (push |=> ptr == {$past(ptr[7:PAGE_BITS]),
      PAGE_BITS'($past(ptr[PAGE_BITS-1:0]) + 1'b1)})
    else $error("page pointer did not wrap in low bits");
  AST_WC_END : assert property ((wcBusy && wcTimer == 24'h1) |=> !wcBusy ##1 !wcBusy)
    else $error("write cycle did not end on count");
endmodule // eewr_slave

// ===== include/eewr_pkg.sv
// constants, types and states shared by the two-wire eeprom slave front end
// Function
// - data line changes only while clock is low during normal bit transfer
// - data edge while clock high is a start or stop, never data
// - respond only when the three select straps match the address select bits
// - write-protect high blocks storing; low lets writes proceed
// - write-protect input ignored on the variant without that pin
// - self-timed write cycle lasts the write cycle time, device unusable meanwhile
// - transmitted data held at least 300 ns after each clock falling edge
// - clock and data pulses up to 50 ns wide are ignored
// - low supply detector blocks all internal erase and write
// - control byte is type code, three select bits, then read/write bit
// - no acknowledge driven while an internal programming cycle runs
// - protected write still acknowledged, nothing stored, full cycle time elapses
// - page write advances only the low four pointer bits, wrapping
package eewr_pkg;
  localparam int CLK_NS      = 40;
  localparam int SYNC_CYC    = 2;
  // spike_filter_width: widest pulse that must be swallowed
  localparam int SPIKE_NS    = 50;
  localparam int FILT_CYC    = (SPIKE_NS + CLK_NS - 1) / CLK_NS + 1;
  // hold of the driven data after the clock falls; the filtered fall already
  // lags the pin by sync plus filter less two cycles, so only the rest is counted
  localparam int HOLD_NS     = 300;
  localparam int HOLD_RAW    = (HOLD_NS + CLK_NS - 1) / CLK_NS - SYNC_CYC - FILT_CYC + 2;
  localparam logic [3:0] HOLD_CYC = 4'((HOLD_RAW < 1) ? 1 : HOLD_RAW);
  // self-timed write cycle
  localparam int WC_MS       = 5;
  localparam int WC_CYC_DEF  = WC_MS * 1000000 / CLK_NS;
  // device type code value is arbitrary
  localparam logic [3:0] DEV_TYPE_DEF = 4'h5;
  // control byte fields
  localparam int CTRL_TYPE_LSB = 4;
  localparam int CTRL_CS_LSB   = 1;
  localparam int CTRL_RW_BIT   = 0;
  localparam int PAGE_BITS     = 4;
  localparam logic [7:0] PTR_RST = 8'h00;
  // pin vector positions after synchronisation
  localparam int PIN_SCL = 0;
  localparam int PIN_SDA = 1;
  localparam int PIN_CS0 = 2;
  localparam int PIN_WP  = 5;
  localparam int PIN_LOW = 6;
  localparam int PIN_N   = 7;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } eewr_wr_s;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX   = 5'h02,
    ST_ACK  = 5'h04,
    ST_TX   = 5'h08,
    ST_MACK = 5'h10
  } eewr_state_e;
endpackage

// ===== verilog/eewr_buf.sv
// two-entry write word buffer with valid/ready on both sides
`timescale 1ns/10ps
module eewr_buf
  import eewr_pkg::*;
#(
  parameter int DEPTH = 2
) (
  input  wire logic     mclk,
  input  wire logic     rst,
  input  wire logic     inValid,
  input  eewr_wr_s      inWord,
  output logic          inReady,
  output logic          outValid,
  output eewr_wr_s      outWord,
  input  wire logic     outReady
);
  // depth must be a power of two so pointers wrap naturally
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  eewr_wr_s        mem [DEPTH];
  logic [PW-1:0]   wrPtr;
  logic [PW-1:0]   rdPtr;
  logic [PW:0]     count;
  logic [PW-1:0]   next_wrPtr;
  logic [PW-1:0]   next_rdPtr;
  logic [PW:0]     next_count;
  logic            push;
  logic            pop;

  assign push    = inValid && inReady;
  assign pop     = outValid && outReady;
  assign outWord = mem[rdPtr];

  // pointer and fill bookkeeping
  always_comb begin
    next_wrPtr = push ? PW'(wrPtr + 1'b1) : wrPtr;
    next_rdPtr = pop ? PW'(rdPtr + 1'b1) : rdPtr;
    next_count = count;
    if (push && !pop) begin
      next_count = (PW + 1)'(count + 1'b1);
    end else if (pop && !push) begin
      next_count = (PW + 1)'(count - 1'b1);
    end
  end

  // flags are registered so both handshakes come from flops
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wrPtr    <= '0;
      rdPtr    <= '0;
      count    <= '0;
      inReady  <= 1'b1;
      outValid <= 1'b0;
    end else begin
      wrPtr    <= next_wrPtr;
      rdPtr    <= next_rdPtr;
      count    <= next_count;
      inReady  <= (next_count != (PW + 1)'(DEPTH));
      outValid <= (next_count != '0);
    end
  end

  // storage is data only, no reset needed
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wrPtr] <= inWord;
    end
  end
endmodule // eewr_buf

// ===== verification/eewr_master_model.sv
// behavioural bus master driving the link clock and the open-drain data line
`timescale 1ns/10ps
module eewr_master_model #(
  parameter int HALF_NS = 640
) (
  output logic      scl,
  output logic      sdaOeN,
  input  wire logic sdaWire
);
  int holdBad = 0;

  // clock stands high outside frames, data released to the pull-up
  initial begin
    scl = 1'b1;
    sdaOeN = 1'b1;
  end

  // one bit; data moves a quarter period after the fall, never while high
  task automatic bitCycle(input logic txBit, output logic rxBit);
    sdaOeN = txBit;
    #(HALF_NS / 2) scl = 1'b1;
    #(HALF_NS / 2) rxBit = sdaWire;
    #(HALF_NS / 2) scl = 1'b0;
    // level must still stand just short of the device's hold time
    #(HALF_NS / 2 - 40) if (sdaWire !== rxBit) holdBad++;
    #40;
  endtask

  // data falls while clock high; also serves as a repeated start
  task automatic startCond();
    sdaOeN = 1'b1;
    #(HALF_NS / 2) scl = 1'b1;
    #(HALF_NS / 2) sdaOeN = 1'b0;
    #(HALF_NS / 2) scl = 1'b0;
    #(HALF_NS / 2);
  endtask

  // data rises while clock high, then bus left idle
  task automatic stopCond();
    sdaOeN = 1'b0;
    #(HALF_NS / 2) scl = 1'b1;
    #(HALF_NS / 2) sdaOeN = 1'b1;
    #(HALF_NS);
  endtask

  // msb first, ninth bit is the device's acknowledge (low = taken)
  task automatic writeByte(input logic [7:0] b, output logic ackN);
    logic r;
    for (int i = 7; i >= 0; i--) bitCycle(b[i], r);
    bitCycle(1'b1, ackN);
  endtask

  task automatic readByte(input logic lastN, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitCycle(1'b1, r);
      b[i] = r;
    end
    bitCycle(lastN, r);
  endtask

  // 40 ns spikes, narrower than the filter must swallow
  task automatic glitch();
    scl = 1'b1;
    #40 scl = 1'b0;
    #(HALF_NS / 2);
  endtask
endmodule // eewr_master_model

// ===== verification/testbench.sv
// self-checking bench for the two-wire eeprom slave front end
`timescale 1ns/10ps
`define CHECK(got, exp) begin num_checks++; if ((got) !== (exp)) begin failures++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module testbench
  import eewr_pkg::*;
;
  localparam int         WC    = 2000;
  localparam logic [3:0] DEV   = 4'h5; // arbitrary type code
  localparam logic [2:0] STRAP = 3'h6;
  logic       mclk, rst, scl, mOeN, dOut, dOeN, sdaWire, wp, lowSup;
  logic       wrValid, wrReady, wrCommit, wcBusy;
  logic [7:0] rdAddr;
  eewr_wr_s   wrWord;
  eewr_wr_s   wq[$];
  int         failures = 0, num_checks = 0, commitCnt = 0, busyCycles = 0;

  // open-drain wire with pull-up
  assign sdaWire = (dOeN ? 1'b1 : dOut) & mOeN;

  eewr_master_model master (.scl(scl), .sdaOeN(mOeN), .sdaWire(sdaWire));

  eewr_slave #(.DEV_TYPE(DEV), .HAS_WP(1'b1), .WC_CYC(WC)) dut (
    .mclk(mclk), .rst(rst), .sclIn(scl), .sdaIn(sdaWire), .sdaOut(dOut), .sdaOeN(dOeN),
    .chipSelectStrap0(STRAP[0]), .chipSelectStrap1(STRAP[1]), .chipSelectStrap2(STRAP[2]),
    .writeProtect(wp), .lowSupply(lowSup), .rdAddr(rdAddr), .rdData(rdAddr ^ 8'h5a),
    .wrValid(wrValid), .wrWord(wrWord), .wrReady(wrReady), .wrCommit(wrCommit),
    .wcBusy(wcBusy));

  // word sink and event counters
  always @(posedge mclk) begin
    if (wrValid && wrReady) wq.push_back(wrWord);
    if (wrCommit) commitCnt++;
    if (wcBusy) busyCycles++;
  end

  task automatic stop_test();
    if (failures == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic frame(input logic [7:0] ctrl, output logic ackN);
    master.startCond();
    master.writeByte(ctrl, ackN);
  endtask

  // bounded wait for the self-timed cycle to end
  task automatic waitIdle();
    for (int i = 0; i < WC + 500 && wcBusy !== 1'b0; i++) @(posedge mclk);
    // step off the edge so pins and outputs never race the sampling flops
    #1;
    `CHECK(wcBusy, 1'b0)
  endtask

  // every select code and a wrong type code; only the strap match answers
  task automatic testSelect();
    logic a;
    for (int cs = 0; cs < 8; cs++) begin
      frame({DEV, 3'(cs), 1'b0}, a);
      master.stopCond();
      `CHECK(a, 1'(3'(cs) != STRAP))
    end
    frame({DEV ^ 4'h8, STRAP, 1'b0}, a);
    master.stopCond();
    `CHECK(a, 1'b1)
  endtask

  // byte write, protect raised mid-frame, then an access while busy
  task automatic testByteWrite();
    logic a;
    int   b0;
    wq.delete();
    b0 = busyCycles;
    frame({DEV, STRAP, 1'b0}, a);
    `CHECK(a, 1'b0)
    @(posedge mclk);
    #1 wp = 1'b1;
    master.writeByte(8'h3e, a);
    master.writeByte(8'ha5, a);
    `CHECK(a, 1'b0)
    master.stopCond();
    `CHECK(wq.size(), 1)
    `CHECK(wq[0], 16'h3ea5)
    `CHECK(commitCnt, 1)
    frame({DEV, STRAP, 1'b0}, a);
    master.stopCond();
    `CHECK(a, 1'b1)
    waitIdle();
    `CHECK(busyCycles - b0, WC)
  endtask

  // protected write, then a write under low supply
  task automatic testProtect();
    logic a;
    int   b0, c0;
    wq.delete();
    b0 = busyCycles;
    c0 = commitCnt;
    frame({DEV, STRAP, 1'b0}, a);
    master.writeByte(8'h05, a);
    master.writeByte(8'h77, a);
    master.stopCond();
    `CHECK(a, 1'b0)
    `CHECK(wq.size(), 0)
    `CHECK(commitCnt, c0)
    waitIdle();
    `CHECK(busyCycles - b0, WC)
    @(posedge mclk);
    #1 wp = 1'b0;
    lowSup = 1'b1;
    frame({DEV, STRAP, 1'b0}, a);
    master.writeByte(8'h06, a);
    master.writeByte(8'h78, a);
    master.stopCond();
    `CHECK(wq.size(), 0)
    `CHECK(commitCnt, c0)
    @(posedge mclk);
    #1 lowSup = 1'b0;
    waitIdle();
  endtask

  // pointer wraps in the low nibble; a spike on each line is ignored
  task automatic testPage();
    logic a;
    wq.delete();
    master.sdaOeN = 1'b0;
    #40 master.sdaOeN = 1'b1;
    frame({DEV, STRAP, 1'b0}, a);
    master.glitch();
    master.writeByte(8'h1e, a);
    master.writeByte(8'h11, a);
    master.writeByte(8'h22, a);
    master.writeByte(8'h33, a);
    master.stopCond();
    `CHECK(wq.size(), 3)
    `CHECK(wq[0], 16'h1e11)
    `CHECK(wq[1], 16'h1f22)
    `CHECK(wq[2], 16'h1033)
    waitIdle();
  endtask

  // sink stalls: two words held, third byte refused, nothing lost
  task automatic testBuffer();
    logic a;
    wq.delete();
    @(posedge mclk);
    #1 wrReady = 1'b0;
    frame({DEV, STRAP, 1'b0}, a);
    master.writeByte(8'h80, a);
    master.writeByte(8'h01, a);
    master.writeByte(8'h02, a);
    master.writeByte(8'h03, a);
    master.stopCond();
    `CHECK(a, 1'b1)
    `CHECK(wq.size(), 0)
    @(posedge mclk);
    #1 wrReady = 1'b1;
    repeat (4) @(posedge mclk);
    `CHECK(wq.size(), 2)
    `CHECK(wq[1], 16'h8102)
    waitIdle();
  endtask

  // set pointer, repeated start, two bytes out
  task automatic testRead();
    logic       a;
    logic [7:0] d;
    frame({DEV, STRAP, 1'b0}, a);
    master.writeByte(8'h40, a);
    frame({DEV, STRAP, 1'b1}, a);
    `CHECK(a, 1'b0)
    master.readByte(1'b0, d);
    `CHECK(d, 8'h40 ^ 8'h5a)
    master.readByte(1'b1, d);
    `CHECK(d, 8'h41 ^ 8'h5a)
    master.stopCond();
    `CHECK(master.holdBad, 0)
  endtask

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // watchdog sized well beyond the whole sequence
  initial begin
    #3000000;
    failures++;
    stop_test();
  end

  initial begin
    rst = 1'b1;
    wp = 1'b0;
    lowSup = 1'b0;
    wrReady = 1'b1;
    repeat (4) @(posedge mclk);
    #1 rst = 1'b0;
    repeat (8) @(posedge mclk);
    testSelect();
    testByteWrite();
    testProtect();
    testPage();
    testBuffer();
    testRead();
    stop_test();
  end
endmodule // testbench
